/* hw/gtr_pkg.sv */
// Constants, field layouts and types shared by the general timer design.
`default_nettype none
package gtr_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int unsigned GTR_ADDR_W = 12;
  localparam int unsigned GTR_IDX_W = 10;
  localparam logic [9:0] GTR_IDX_COUNT = 10'h100;
  localparam logic [9:0] GTR_IDX_PERIOD = 10'h102;
  localparam logic [9:0] GTR_IDX_CONTROL = 10'h104;
  localparam logic [9:0] GTR_IDX_IRQ_STATUS = 10'h110;
  localparam logic [9:0] GTR_IDX_IRQ_ENABLE = 10'h111;
  localparam logic [9:0] GTR_IDX_IRQ_CLEAR = 10'h112;
  localparam logic [9:0] GTR_IDX_OSC_CTRL = 10'h113;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned GTR_BIT_TIMER_ON = 15;
  localparam int unsigned GTR_BIT_IDLE_STOP = 13;
  localparam int unsigned GTR_BIT_GATE = 6;
  localparam int unsigned GTR_BIT_PS_HI = 5;
  localparam int unsigned GTR_BIT_PS_LO = 4;
  localparam int unsigned GTR_BIT_SYNC = 2;
  localparam int unsigned GTR_BIT_SOURCE = 1;
  localparam int unsigned GTR_BIT_LP_OSC = 1;
  localparam int unsigned GTR_IRQ_W = 2;
  localparam int unsigned GTR_IRQ_TIMER = 0;
  localparam int unsigned GTR_IRQ_WAKE = 1;
  // ---------------------------------------------------------------
  // Reset values and prescaler terminal counts
  // ---------------------------------------------------------------
  localparam logic [15:0] GTR_RST_COUNT = 16'h0000;
  localparam logic [15:0] GTR_RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] GTR_RST_CONTROL = 16'h0000;
  localparam logic [7:0] GTR_PS_TERM_1 = 8'h00;
  localparam logic [7:0] GTR_PS_TERM_8 = 8'h07;
  localparam logic [7:0] GTR_PS_TERM_64 = 8'h3F;
  localparam logic [7:0] GTR_PS_TERM_256 = 8'hFF;
  localparam int unsigned GTR_SYNC_PINS = 2;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic timer_on;
    logic idle_stop;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic external_clock_sync;
    logic clock_source_select;
  } gtr_ctrl_t;
  typedef enum logic [2:0] {
    GTR_OFF = 3'b000,
    GTR_INTERNAL = 3'b001,
    GTR_GATED = 3'b011,
    GTR_SYNC_EXT = 3'b010,
    GTR_ASYNC_EXT = 3'b110,
    GTR_LP_OSC = 3'b111
  } gtr_mode_t;
endpackage : gtr_pkg
`default_nettype wire

/* hw/gtr_prescaler.sv */
// Clock prescaler that passes one input tick out of every terminal plus one.
`default_nettype none
module gtr_prescaler
  import gtr_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [WIDTH-1:0] terminal,
  output logic tick_out
);
  logic [WIDTH-1:0] count;

  assign tick_out = tick_in && (count == terminal);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick_in) begin
      if (count == terminal) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule : gtr_prescaler
`default_nettype wire

/* hw/gtr_timer.sv */
// General purpose 16-bit timer with period match, gating, prescaler and RTC mode.
//
// Local design decision: the APB slave port.
`default_nettype none
module gtr_timer
  import gtr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GTR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic external_clock_gate_pin,
  input wire logic lp_osc_clk,
  output logic irq,
  output logic wake_event
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  gtr_ctrl_t ctrl;
  gtr_mode_t mode;
  logic low_power_osc_enable;
  logic [15:0] timer_count;
  logic [15:0] timer_period;

  // ---------------------------------------------------------------
  // Interrupt signals
  // ---------------------------------------------------------------
  logic [GTR_IRQ_W-1:0] irq_status;
  logic [GTR_IRQ_W-1:0] irq_enable;
  logic [GTR_IRQ_W-1:0] next_irq_status;
  logic [GTR_IRQ_W-1:0] irq_set;
  logic [GTR_IRQ_W-1:0] irq_clr;

  // ---------------------------------------------------------------
  // Pin sampling signals
  // ---------------------------------------------------------------
  logic [GTR_SYNC_PINS-1:0] pin_raw;
  logic [GTR_SYNC_PINS-1:0] pin_meta;
  logic [GTR_SYNC_PINS-1:0] pin_sync;
  logic [GTR_SYNC_PINS-1:0] pin_prev;
  logic gate_level;
  logic ext_rise;
  logic lp_rise;
  logic gate_fall;

  // ---------------------------------------------------------------
  // Bus decode signals
  // ---------------------------------------------------------------
  logic [GTR_IDX_W-1:0] idx;
  logic setup_rd;
  logic access;
  logic wr;
  logic mapped;
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_irq_enable;
  logic wr_irq_clear;
  logic wr_osc;

  // ---------------------------------------------------------------
  // Counting signals
  // ---------------------------------------------------------------
  logic raw_tick;
  logic idle_hold;
  logic sleep_hold;
  logic run;
  logic ps_clear;
  logic ps_tick;
  logic ps_in;
  logic [7:0] ps_terminal;
  logic match;
  logic [31:0] next_prdata;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  assign pin_raw = {lp_osc_clk, external_clock_gate_pin};

  for (genvar i = 0; i < GTR_SYNC_PINS; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_meta[i] <= 1'b0;
        pin_sync[i] <= 1'b0;
      end else begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_prev[i] <= 1'b0;
      end else begin
        pin_prev[i] <= pin_sync[i];
      end
    end
  end

  assign gate_level = pin_sync[0];
  assign ext_rise = pin_sync[0] && !pin_prev[0];
  assign lp_rise = pin_sync[1] && !pin_prev[1];
  assign gate_fall = !pin_sync[0] && pin_prev[0];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign idx = paddr[GTR_ADDR_W-1:2];
  assign setup_rd = psel && !penable && !pwrite;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign pready = 1'b1;

  always_comb begin
    unique case (idx)
      GTR_IDX_COUNT,
      GTR_IDX_PERIOD,
      GTR_IDX_CONTROL,
      GTR_IDX_IRQ_STATUS,
      GTR_IDX_IRQ_ENABLE,
      GTR_IDX_IRQ_CLEAR,
      GTR_IDX_OSC_CTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = access && !mapped;
  assign wr_count = wr && (idx == GTR_IDX_COUNT);
  assign wr_period = wr && (idx == GTR_IDX_PERIOD);
  assign wr_control = wr && (idx == GTR_IDX_CONTROL);
  assign wr_irq_enable = wr && (idx == GTR_IDX_IRQ_ENABLE);
  assign wr_irq_clear = wr && (idx == GTR_IDX_IRQ_CLEAR);
  assign wr_osc = wr && (idx == GTR_IDX_OSC_CTRL);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (idx)
      GTR_IDX_COUNT: next_prdata[15:0] = timer_count;
      GTR_IDX_PERIOD: next_prdata[15:0] = timer_period;
      GTR_IDX_CONTROL: begin
        next_prdata[GTR_BIT_TIMER_ON] = ctrl.timer_on;
        next_prdata[GTR_BIT_IDLE_STOP] = ctrl.idle_stop;
        next_prdata[GTR_BIT_GATE] = ctrl.gate_accumulate_enable;
        next_prdata[GTR_BIT_PS_HI:GTR_BIT_PS_LO] = ctrl.prescale_select;
        next_prdata[GTR_BIT_SYNC] = ctrl.external_clock_sync;
        next_prdata[GTR_BIT_SOURCE] = ctrl.clock_source_select;
      end
      GTR_IDX_IRQ_STATUS: next_prdata[GTR_IRQ_W-1:0] = irq_status;
      GTR_IDX_IRQ_ENABLE: next_prdata[GTR_IRQ_W-1:0] = irq_enable;
      GTR_IDX_OSC_CTRL: next_prdata[GTR_BIT_LP_OSC] = low_power_osc_enable;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else if (wr_control) begin
      ctrl.timer_on <= pwdata[GTR_BIT_TIMER_ON];
      ctrl.idle_stop <= pwdata[GTR_BIT_IDLE_STOP];
      ctrl.gate_accumulate_enable <= pwdata[GTR_BIT_GATE];
      ctrl.prescale_select <= pwdata[GTR_BIT_PS_HI:GTR_BIT_PS_LO];
      ctrl.external_clock_sync <= pwdata[GTR_BIT_SYNC];
      ctrl.clock_source_select <= pwdata[GTR_BIT_SOURCE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_osc_enable <= 1'b0;
    end else if (wr_osc) begin
      low_power_osc_enable <= pwdata[GTR_BIT_LP_OSC];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_period <= GTR_RST_PERIOD;
    end else if (wr_period) begin
      timer_period <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Mode selection
  // ---------------------------------------------------------------
  always_comb begin
    if (!ctrl.timer_on) begin
      mode = GTR_OFF;
    end else if (low_power_osc_enable) begin
      if (ctrl.clock_source_select && !ctrl.gate_accumulate_enable) begin
        mode = GTR_LP_OSC;
      end else begin
        mode = GTR_OFF;
      end
    end else if (!ctrl.clock_source_select) begin
      mode = ctrl.gate_accumulate_enable ? GTR_GATED : GTR_INTERNAL;
    end else begin
      mode = ctrl.external_clock_sync ? GTR_SYNC_EXT : GTR_ASYNC_EXT;
    end
  end

  always_comb begin
    unique case (mode)
      GTR_OFF: raw_tick = 1'b0;
      GTR_INTERNAL: raw_tick = 1'b1;
      GTR_GATED: raw_tick = gate_level;
      GTR_SYNC_EXT: raw_tick = ext_rise;
      GTR_ASYNC_EXT: raw_tick = ext_rise;
      GTR_LP_OSC: raw_tick = lp_rise;
      default: raw_tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Idle and sleep gating
  // ---------------------------------------------------------------
  assign idle_hold = cpu_idle && ctrl.idle_stop;
  assign sleep_hold = cpu_sleep && !(ctrl.clock_source_select && !ctrl.external_clock_sync);
  assign run = !idle_hold && !sleep_hold;

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  always_comb begin
    unique case (ctrl.prescale_select)
      2'h0: ps_terminal = GTR_PS_TERM_1;
      2'h1: ps_terminal = GTR_PS_TERM_8;
      2'h2: ps_terminal = GTR_PS_TERM_64;
      2'h3: ps_terminal = GTR_PS_TERM_256;
    endcase
  end

  assign ps_clear = ctrl.timer_on && (wr_count || wr_control);

  assign ps_in = raw_tick && run;

  gtr_prescaler #(
    .WIDTH(8)
  ) gtr_prescaler_i (
    .pclk(pclk),
    .presetn(presetn),
    .clear(ps_clear),
    .tick_in(ps_in),
    .terminal(ps_terminal),
    .tick_out(ps_tick)
  );

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  assign match = ps_tick && (timer_count == timer_period);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= GTR_RST_COUNT;
    end else if (wr_count) begin
      timer_count <= pwdata[15:0];
    end else if (match) begin
      timer_count <= 16'h0000;
    end else if (ps_tick) begin
      timer_count <= timer_count + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts and wake-up
  // ---------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[GTR_IRQ_TIMER] = match || (mode == GTR_GATED && gate_fall);
    irq_set[GTR_IRQ_WAKE] = match && (mode == GTR_LP_OSC);
    irq_clr = wr_irq_clear ? pwdata[GTR_IRQ_W-1:0] : '0;
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= '0;
    end else if (wr_irq_enable) begin
      irq_enable <= pwdata[GTR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= irq_set[GTR_IRQ_WAKE];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt output
  // ---------------------------------------------------------------
  assign irq = |(irq_status & irq_enable);
endmodule : gtr_timer
`default_nettype wire

/* verif/gtr_timer_props.sv */
// Port assertions for the general timer.
`default_nettype none
module gtr_timer_props
  import gtr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GTR_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic wake_event
);
  // ----------
  // Decode
  // ----------
  logic [9:0] idx;
  logic acc;
  logic rd;
  logic mapped;
  assign idx = paddr[11:2];
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign mapped = idx inside {GTR_IDX_COUNT, GTR_IDX_PERIOD, GTR_IDX_CONTROL, GTR_IDX_IRQ_STATUS,
    GTR_IDX_IRQ_ENABLE, GTR_IDX_IRQ_CLEAR, GTR_IDX_OSC_CTRL};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------
  // Checks
  // ----------
  ready_high_a: assert property (pready) else $error("pready low");
  err_unmapped_a: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
  err_only_a: assert property (pslverr |-> acc && !mapped) else $error("stray pslverr");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
  ctrl_bits_a: assert property (rd && idx == GTR_IDX_CONTROL |-> (prdata & 32'hFFFF5F89) == 32'h00000000)
    else $error("control spare bits set");
  zero_read_a: assert property (rd && (!mapped || idx == GTR_IDX_IRQ_CLEAR) |-> prdata == 32'h00000000)
    else $error("nonzero read");
  wake_pulse_a: assert property (wake_event |=> !wake_event) else $error("wake too long");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc && pwrite)) else $error("irq fell alone");
  irq_c: cover property ($rose(irq));
  wake_c: cover property (wake_event);
  err_c: cover property (pslverr);
endmodule : gtr_timer_props
bind gtr_timer gtr_timer_props gtr_timer_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .wake_event(wake_event));
`default_nettype wire

/* verif/gtr_ext_model.sv */
// External clock, gate and low-power oscillator source.
`default_nettype none
module gtr_ext_model
  import gtr_pkg::*;
#(
  parameter int LP_HALF_NS = 15625,
  parameter int PULSE_HALF_NS = 400
) (
  input wire logic pulse_go,
  input wire logic [7:0] pulse_n,
  input wire logic gate_level,
  input wire logic lp_run,
  output logic ext_pin,
  output logic lp_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pulse_q = 1'b0;
  // Bursts and gate level share the pin, which rests low.
  assign ext_pin = pulse_q | gate_level;
  always @(posedge pulse_go) begin
    for (int k = 0; k < int'(pulse_n); k++) begin
      #PULSE_HALF_NS pulse_q = 1'b1;
      #PULSE_HALF_NS pulse_q = 1'b0;
    end
  end
  // The oscillator stands low while it is stopped.
  initial begin
    lp_clk = 1'b0;
    forever begin
      #LP_HALF_NS;
      lp_clk = lp_run ? ~lp_clk : 1'b0;
    end
  end
endmodule : gtr_ext_model
`default_nettype wire

/* verif/gtr_timer_tb.sv */
// Self-checking bench for the general timer.
`default_nettype none
module gtr_timer_tb
  import gtr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ON = 32'h00008000;
  localparam logic [31:0] IDL = 32'h00002000;
  localparam logic [31:0] GT = 32'h00000040;
  localparam logic [31:0] SYN = 32'h00000004;
  localparam logic [31:0] SRC = 32'h00000002;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_idle = 1'b1;
  logic cpu_sleep = 1'b0;
  logic ext_pin;
  logic lp_clk;
  logic irq;
  logic wake_event;
  logic go = 1'b0;
  logic gate = 1'b0;
  logic lp_run = 1'b0;
  logic err;
  logic [31:0] q;
  logic [31:0] a;
  int mismatches = 0;
  int checks = 0;
  int wakes = 0;
  logic [31:0] cc [6] = '{ON | SRC | SYN, ON | SRC, ON | SRC, ON | SRC | SYN, ON | SRC | IDL, ON | SRC | SYN | IDL};
  logic [1:0] cs [6] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1};
  logic [2:0] ce [6] = '{3'h5, 3'h5, 3'h5, 3'h0, 3'h0, 3'h0};
  gtr_timer gtr_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .external_clock_gate_pin(ext_pin), .lp_osc_clk(lp_clk), .irq(irq),
    .wake_event(wake_event));
  gtr_ext_model gtr_ext_model_i (.pulse_go(go), .pulse_n(8'h05), .gate_level(gate), .lp_run(lp_run),
    .ext_pin(ext_pin), .lp_clk(lp_clk));
  // ----------
  // Tasks
  // ----------
  task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic ok(input logic c, input string m);
    checks++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : ok
  task automatic chk(input logic [9:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h00000000);
    ok(q === e, "register read");
  endtask : chk
  task automatic run(input int n);
    cpu_idle <= 1'b0;
    repeat (n) @(posedge pclk);
    cpu_idle <= 1'b1;
  endtask : run
  task automatic irq_is(input logic e);
    @(negedge pclk);
    ok(irq === e, "irq level");
  endtask : irq_is
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // ----------
  // Stimulus
  // ----------
  initial begin
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
  always @(negedge pclk) begin
    if (wake_event === 1'b1) begin
      wakes++;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(GTR_IDX_COUNT, 32'h00000000);
    chk(GTR_IDX_PERIOD, 32'h0000FFFF);
    chk(GTR_IDX_CONTROL, 32'h00000000);
    xfer(1'b1, 10'h3FF, 32'hFFFFFFFF);
    ok(err === 1'b1, "unmapped write");
    xfer(1'b1, GTR_IDX_CONTROL, 32'hFFFFFFFF);
    chk(GTR_IDX_CONTROL, 32'h0000A076);
    xfer(1'b1, GTR_IDX_IRQ_STATUS, 32'h00000003);
    chk(GTR_IDX_IRQ_STATUS, 32'h00000000);
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, GTR_IDX_CONTROL, ON | IDL | (32'(p) << 4));
      xfer(1'b1, GTR_IDX_COUNT, 32'h00000000);
      run(3 * (p == 3 ? 256 : 1 << (3 * p)));
      chk(GTR_IDX_COUNT, 32'h00000003);
    end
    xfer(1'b1, GTR_IDX_CONTROL, ON | IDL);
    chk(GTR_IDX_COUNT, 32'h00000003);
    xfer(1'b1, GTR_IDX_PERIOD, 32'h00000004);
    xfer(1'b1, GTR_IDX_COUNT, 32'h00000000);
    run(7);
    chk(GTR_IDX_COUNT, 32'h00000002);
    chk(GTR_IDX_IRQ_STATUS, 32'h00000001);
    irq_is(1'b0);
    xfer(1'b1, GTR_IDX_IRQ_ENABLE, 32'h00000001);
    irq_is(1'b1);
    xfer(1'b1, GTR_IDX_IRQ_CLEAR, 32'h00000001);
    irq_is(1'b0);
    chk(GTR_IDX_IRQ_CLEAR, 32'h00000000);
    xfer(1'b1, GTR_IDX_PERIOD, 32'h0000FFFF);
    xfer(1'b1, GTR_IDX_CONTROL, ON);
    xfer(1'b0, GTR_IDX_COUNT, 32'h00000000);
    a = q;
    chk(GTR_IDX_COUNT, a + 32'h00000003);
    cpu_sleep <= 1'b1;
    xfer(1'b0, GTR_IDX_COUNT, 32'h00000000);
    a = q;
    chk(GTR_IDX_COUNT, a);
    for (int k = 0; k < 6; k++) begin
      cpu_sleep <= cs[k][1];
      cpu_idle <= cs[k][0];
      xfer(1'b1, GTR_IDX_CONTROL, cc[k]);
      xfer(1'b1, GTR_IDX_COUNT, 32'h00000000);
      go <= 1'b1;
      repeat (50) @(posedge pclk);
      go <= 1'b0;
      chk(GTR_IDX_COUNT, 32'(ce[k]));
    end
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b0;
    xfer(1'b1, GTR_IDX_CONTROL, ON | GT);
    xfer(1'b1, GTR_IDX_COUNT, 32'h00000000);
    xfer(1'b1, GTR_IDX_IRQ_CLEAR, 32'h00000003);
    gate <= 1'b1;
    repeat (10) @(posedge pclk);
    gate <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(GTR_IDX_COUNT, 32'h0000000A);
    chk(GTR_IDX_IRQ_STATUS, 32'h00000001);
    xfer(1'b1, GTR_IDX_IRQ_CLEAR, 32'h00000003);
    xfer(1'b1, GTR_IDX_OSC_CTRL, 32'h00000002);
    xfer(1'b1, GTR_IDX_PERIOD, 32'h00000001);
    xfer(1'b1, GTR_IDX_CONTROL, ON | SRC);
    xfer(1'b1, GTR_IDX_COUNT, 32'h00000000);
    cpu_sleep <= 1'b1;
    lp_run <= 1'b1;
    repeat (1400) @(posedge pclk);
    lp_run <= 1'b0;
    cpu_sleep <= 1'b0;
    repeat (400) @(posedge pclk);
    ok(wakes == 2, "wake count");
    chk(GTR_IDX_IRQ_STATUS, 32'h00000003);
    xfer(1'b1, GTR_IDX_CONTROL, ON);
    xfer(1'b0, GTR_IDX_COUNT, 32'h00000000);
    a = q;
    chk(GTR_IDX_COUNT, a);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    irq_is(1'b0);
    chk(GTR_IDX_CONTROL, 32'h00000000);
    chk(GTR_IDX_IRQ_STATUS, 32'h00000000);
    finish_test();
  end
endmodule : gtr_timer_tb
`default_nettype wire
